// ---- shared/wsa_map.svh ----
// Constants of the word store alignment block
`ifndef WSA_MAP_SVH
`define WSA_MAP_SVH

// ****************************************
// Instruction fields
// ****************************************
`define WSA_OPC_MSB        31
`define WSA_OPC_LSB        26
`define WSA_OFF_MSB        15
`define WSA_OFF_LSB        0
`define WSA_OPC_WORD_STORE 6'h2B
`define WSA_OPC_LEFT_STORE 6'h2A

// ****************************************
// Reset values and word byte enable
// ****************************************
`define WSA_RST_ADDR       32'h0000_0000
`define WSA_RST_WORD       32'h0000_0000
`define WSA_RST_DATA       128'h0
`define WSA_RST_BEN        16'h0000
`define WSA_WORD_BEN       16'h000F

`endif

// ---- shared/wsa_pkg.sv ----
// Types of the word store alignment block
package wsa_pkg;

    typedef enum logic [1:0] {
        WSA_ST_IDLE = 2'b00,
        WSA_ST_XLAT = 2'b01
    } wsa_state_e;

    typedef enum logic [1:0] {
        WSA_K_NONE = 2'b00,
        WSA_K_WORD = 2'b01,
        WSA_K_LEFT = 2'b10
    } wsa_kind_e;

    typedef enum logic [2:0] {
        WSA_EXC_NONE     = 3'h0,
        WSA_EXC_ADDR     = 3'h1,
        WSA_EXC_REFILL   = 3'h2,
        WSA_EXC_INVALID  = 3'h3,
        WSA_EXC_MODIFIED = 3'h4,
        WSA_EXC_NOSTORE  = 3'h5
    } wsa_exc_e;

    typedef struct packed {
        logic [31:0] instr;
        logic [63:0] base;
        logic [63:0] src;
    } wsa_req_s;

    typedef struct packed {
        logic [31:0] paddr;
        logic        refill;
        logic        invalid;
        logic        modified;
    } wsa_xlat_s;

    typedef struct packed {
        logic [31:0]  addr;
        logic [127:0] data;
        logic [15:0]  ben;
    } wsa_store_s;

endpackage

// ---- rtl/wsa_store_align.sv ----
// Store data alignment for aligned and left-part word stores
`timescale 1ns/100ps
`include "wsa_map.svh"

module wsa_store_align #(
    parameter logic [5:0] WORD_OPC = `WSA_OPC_WORD_STORE,
    parameter logic [5:0] LEFT_OPC = `WSA_OPC_LEFT_STORE
) (
    input  wire logic                sys_clk_i,
    input  wire logic                sys_rst_i,
    input  wire logic                req_valid_i,
    output wire logic                req_ready_o,
    input  wire wsa_pkg::wsa_req_s   req_i,
    input  wire logic                endian_select_i,
    output wire logic                xlat_req_o,
    output wire logic [31:0]         virt_addr_o,
    input  wire logic                xlat_valid_i,
    input  wire wsa_pkg::wsa_xlat_s  xlat_i,
    output wire logic                store_valid_o,
    output wire wsa_pkg::wsa_store_s store_o,
    output wire logic                done_o,
    output wire wsa_pkg::wsa_exc_e   exc_o
);
    import wsa_pkg::*;

    // ****************************************
    // Functions
    // ****************************************
    function automatic logic [31:0] f_eff_addr(
        input logic [63:0] base,
        input logic [15:0] off
    );
        f_eff_addr = base[31:0] + {{16{off[15]}}, off};
    endfunction

    function automatic wsa_kind_e f_kind(input logic [31:0] instr);
        logic [5:0] opc;
        opc = instr[`WSA_OPC_MSB:`WSA_OPC_LSB];
        if (opc == WORD_OPC) begin
            f_kind = WSA_K_WORD;
        end else if (opc == LEFT_OPC) begin
            f_kind = WSA_K_LEFT;
        end else begin
            f_kind = WSA_K_NONE;
        end
    endfunction

    // Bytes 0..b of a word; the top register byte lands on b
    function automatic logic [3:0] f_left_mask(input logic [1:0] b);
        case (b)
            2'h0:    f_left_mask = 4'h1;
            2'h1:    f_left_mask = 4'h3;
            2'h2:    f_left_mask = 4'h7;
            default: f_left_mask = 4'hF;
        endcase
    endfunction

    function automatic wsa_store_s f_place(
        input wsa_kind_e   kind,
        input logic [31:0] virt_addr,
        input logic        big,
        input logic [31:0] word,
        input logic [31:0] paddr
    );
        logic [1:0]  w;
        logic [1:0]  b;
        logic [31:0] part;
        w    = virt_addr[3:2] ^ {2{big}};
        b    = virt_addr[1:0] ^ {2{big}};
        part = word >> {2'h3 - b, 3'h0};
        if (kind == WSA_K_WORD) begin
            f_place.data = {96'h0, word} << {w, 5'h0};
            f_place.ben  = `WSA_WORD_BEN << {w, 2'h0};
            f_place.addr = {paddr[31:4], paddr[3:0] ^ {big, big, 2'h0}};
        end else begin
            f_place.data = {96'h0, part} << {w, 5'h0};
            f_place.ben  = {12'h0, f_left_mask(b)} << {w, 2'h0};
            if (big) begin
                f_place.addr = {paddr[31:4], paddr[3:0] ^ 4'hF};
            end else begin
                f_place.addr = {paddr[31:2], 2'h0};
            end
        end
    endfunction

    // ****************************************
    // State
    // ****************************************
    wsa_state_e  state_r, state_nxt;
    wsa_kind_e   kind_r, kind_nxt;
    logic [31:0] virt_addr_r, virt_addr_nxt;
    logic        big_r, big_nxt;
    logic [31:0] word_r, word_nxt;
    logic        done_r, done_nxt;
    wsa_exc_e    exc_r, exc_nxt;
    logic        stv_r, stv_nxt;
    wsa_store_s  store_r, store_nxt;

    logic        taken;
    logic [31:0] eff;
    wsa_kind_e   kind_dec;
    logic        fault;

    assign taken    = req_valid_i && req_ready_o;
    assign eff      = f_eff_addr(req_i.base, req_i.instr[`WSA_OFF_MSB:`WSA_OFF_LSB]);
    assign kind_dec = f_kind(req_i.instr);
    assign fault    = xlat_i.refill || xlat_i.invalid || xlat_i.modified;

    assign req_ready_o   = (state_r == WSA_ST_IDLE);
    assign xlat_req_o    = (state_r == WSA_ST_XLAT);
    assign virt_addr_o   = virt_addr_r;
    assign store_valid_o = stv_r;
    assign store_o       = store_r;
    assign done_o        = done_r;
    assign exc_o         = exc_r;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        state_nxt = state_r;
        kind_nxt  = kind_r;
        virt_addr_nxt = virt_addr_r;
        big_nxt   = big_r;
        word_nxt  = word_r;
        done_nxt  = 1'b0;
        exc_nxt   = exc_r;
        stv_nxt   = 1'b0;
        store_nxt = store_r;
        case (state_r)
            WSA_ST_IDLE: begin
                if (req_valid_i) begin
                    kind_nxt  = kind_dec;
                    virt_addr_nxt = eff;
                    big_nxt   = endian_select_i;
                    word_nxt  = req_i.src[31:0];
                    if (kind_dec == WSA_K_NONE) begin
                        done_nxt = 1'b1;
                        exc_nxt  = WSA_EXC_NOSTORE;
                    end else if (kind_dec == WSA_K_WORD && eff[1:0] != 2'h0) begin
                        // Caught before translation, so no write is ever built
                        done_nxt = 1'b1;
                        exc_nxt  = WSA_EXC_ADDR;
                    end else begin
                        // Left-part form never checks alignment
                        state_nxt = WSA_ST_XLAT;
                    end
                end
            end
            WSA_ST_XLAT: begin
                if (xlat_valid_i) begin
                    state_nxt = WSA_ST_IDLE;
                    done_nxt  = 1'b1;
                    if (xlat_i.refill) begin
                        exc_nxt = WSA_EXC_REFILL;
                    end else if (xlat_i.invalid) begin
                        exc_nxt = WSA_EXC_INVALID;
                    end else if (xlat_i.modified) begin
                        exc_nxt = WSA_EXC_MODIFIED;
                    end else begin
                        exc_nxt   = WSA_EXC_NONE;
                        stv_nxt   = 1'b1;
                        store_nxt = f_place(kind_r, virt_addr_r, big_r, word_r, xlat_i.paddr);
                    end
                end
            end
            default: begin
                state_nxt = WSA_ST_IDLE;
            end
        endcase
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            state_r <= WSA_ST_IDLE;
            kind_r  <= WSA_K_NONE;
            virt_addr_r <= `WSA_RST_ADDR;
            big_r   <= 1'b0;
            word_r  <= `WSA_RST_WORD;
            done_r  <= 1'b0;
            exc_r   <= WSA_EXC_NONE;
            stv_r   <= 1'b0;
            store_r <= '{addr: `WSA_RST_ADDR, data: `WSA_RST_DATA, ben: `WSA_RST_BEN};
        end else begin
            state_r <= state_nxt;
            kind_r  <= kind_nxt;
            virt_addr_r <= virt_addr_nxt;
            big_r   <= big_nxt;
            word_r  <= word_nxt;
            done_r  <= done_nxt;
            exc_r   <= exc_nxt;
            stv_r   <= stv_nxt;
            store_r <= store_nxt;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    // Lane and byte position of the store now on the outputs
    logic [1:0] a_w;
    logic [1:0] a_b;
    logic [6:0] a_top;
    assign a_w   = virt_addr_r[3:2] ^ {2{big_r}};
    assign a_b   = virt_addr_r[1:0] ^ {2{big_r}};
    assign a_top = {a_w, a_b, 3'h0};

    sequence s_take_store;
        taken && kind_dec != WSA_K_NONE && !(kind_dec == WSA_K_WORD && eff[1:0] != 2'h0);
    endsequence

    sequence s_clean_xlat;
        xlat_req_o && xlat_valid_i && !fault;
    endsequence

    sequence s_fault_xlat;
        xlat_req_o && xlat_valid_i && fault;
    endsequence

    a_word_opcode: assert property (taken && req_i.instr[31:26] == 6'h2B
        |=> kind_r == WSA_K_WORD)
        else $error("opcode 101011 not taken as aligned word store");

    a_nostore_opc: assert property (taken && kind_dec == WSA_K_NONE
        |=> done_o && exc_o == WSA_EXC_NOSTORE && !xlat_req_o && !store_valid_o)
        else $error("non-store opcode not refused");

    a_eff_addr: assert property (taken |=> virt_addr_r ==
        $past(req_i.base[31:0]) + {{16{$past(req_i.instr[15])}}, $past(req_i.instr[15:0])})
        else $error("effective address wrong");

    a_xlat_hold: assert property (xlat_req_o && !xlat_valid_i
        |=> xlat_req_o && $stable(virt_addr_o))
        else $error("address not held while waiting for translation");

    a_misalign_err: assert property (taken && kind_dec == WSA_K_WORD && eff[1:0] != 2'h0
        |=> done_o && exc_o == WSA_EXC_ADDR && !store_valid_o ##1 !store_valid_o)
        else $error("misaligned word store not refused");

    a_word_xlat: assert property (taken && kind_dec == WSA_K_WORD && eff[1:0] == 2'h0
        |=> xlat_req_o && !done_o)
        else $error("aligned word store not sent to translation");

    a_store_flow: assert property (s_take_store ##1 s_clean_xlat
        |=> store_valid_o && done_o && exc_o == WSA_EXC_NONE)
        else $error("clean store not issued one cycle after translation");

    a_word_lane: assert property (store_valid_o && kind_r == WSA_K_WORD
        |-> store_o.ben == (16'h000F << {a_w, 2'h0})
        && store_o.data[{a_w, 5'h0} +: 32] == word_r)
        else $error("aligned word lane or data wrong");

    a_left_top: assert property (store_valid_o && kind_r == WSA_K_LEFT
        |-> store_o.data[a_top +: 8] == word_r[31:24]
        && $countones(store_o.ben) == 32'(a_b) + 1)
        else $error("left-part top byte or byte count wrong");

    // Lowest byte of the word gets the register byte that ends the run
    a_left_low: assert property (store_valid_o && kind_r == WSA_K_LEFT
        |-> store_o.data[{a_w, 5'h0} +: 8] == word_r[{2'h3 - a_b, 3'h0} +: 8])
        else $error("left-part low byte wrong");

    a_left_word: assert property (store_valid_o && kind_r == WSA_K_LEFT
        |-> (store_o.ben & ~(16'h000F << {a_w, 2'h0})) == 16'h0000)
        else $error("left-part store leaves its word");

    a_left_noerr: assert property (taken && kind_dec == WSA_K_LEFT
        |=> !done_o && xlat_req_o)
        else $error("left-part store refused on alignment");

    a_be_full: assert property (store_valid_o && kind_r == WSA_K_LEFT && big_r
        && virt_addr_r[1:0] == 2'h0 |-> $countones(store_o.ben) == 4)
        else $error("big-endian position zero not four bytes");

    a_le_addr: assert property (store_valid_o && kind_r == WSA_K_LEFT && !big_r
        |-> store_o.addr[1:0] == 2'h0)
        else $error("little-endian left-part address not cleared");

    a_fault_drop: assert property (s_fault_xlat
        |=> done_o && !store_valid_o && exc_o inside {WSA_EXC_REFILL,
        WSA_EXC_INVALID, WSA_EXC_MODIFIED})
        else $error("translation fault did not suppress the store");

    // Refill outranks invalid, which outranks modified
    a_refill_first: assert property (xlat_req_o && xlat_valid_i && xlat_i.refill
        |=> exc_o == WSA_EXC_REFILL)
        else $error("refill fault not reported first");

    a_invalid_next: assert property (xlat_req_o && xlat_valid_i && !xlat_i.refill
        && xlat_i.invalid |=> exc_o == WSA_EXC_INVALID)
        else $error("invalid fault not reported");

    a_modified_last: assert property (xlat_req_o && xlat_valid_i && !xlat_i.refill
        && !xlat_i.invalid && xlat_i.modified |=> exc_o == WSA_EXC_MODIFIED)
        else $error("modified fault not reported");

    a_store_clean: assert property (store_valid_o
        |-> done_o && exc_o == WSA_EXC_NONE)
        else $error("store issued with an exception");

    a_store_once: assert property (store_valid_o
        |=> !store_valid_o)
        else $error("store pulse longer than one cycle");

endmodule

// ---- verif/wsa_xlat_model.sv ----
// Translation stage stand-in on the far side of the store alignment block
`timescale 1ns/100ps
module wsa_xlat_model (
    input  wire logic          sys_clk_i,
    input  wire logic          xlat_req_i,
    input  wire logic [31:0]   virt_addr_i,
    input  wire logic [3:0]    delay_i,
    input  wire logic [2:0]    fault_i,
    output logic               xlat_valid_o,
    output wsa_pkg::wsa_xlat_s xlat_o
);
    import wsa_pkg::*;
    // ****************************************
    // Answer after a set wait
    // ****************************************
    // Page bit flipped so an untranslated address shows up
    localparam logic [31:0] PA_XOR = 32'h4000_0000;
    logic [3:0]             wait_cnt;
    initial begin
        xlat_valid_o = 1'b0;
        xlat_o = '0;
        wait_cnt = 4'h0;
    end
    // Outside the answer cycle the fields toggle, never hold stale values
    always @(negedge sys_clk_i) begin
        if (xlat_req_i && !xlat_valid_o && wait_cnt >= delay_i) begin
            xlat_valid_o <= 1'b1;
            xlat_o <= {virt_addr_i ^ PA_XOR, fault_i};
        end else begin
            xlat_valid_o <= 1'b0;
            xlat_o <= ~xlat_o;
        end
        wait_cnt <= (xlat_req_i && !xlat_valid_o) ? wait_cnt + 4'h1 : 4'h0;
    end
endmodule

// ---- verif/testbench.sv ----
// Self-checking bench of the store alignment block
`timescale 1ns/100ps
`include "wsa_map.svh"
module testbench;
    import wsa_pkg::*;
    // ****************************************
    // Signals
    // ****************************************
    localparam logic [31:0] PA_XOR = 32'h4000_0000;
    logic                   sys_clk_i;
    logic                   sys_rst_i;
    logic                   req_valid_i;
    logic                   req_ready_o;
    wsa_req_s               req_i;
    logic                   endian_select_i;
    logic                   xlat_req_o;
    logic [31:0]            virt_addr_o;
    logic                   xlat_valid_i;
    wsa_xlat_s              xlat_i;
    logic                   store_valid_o;
    wsa_store_s             store_o;
    logic                   done_o;
    wsa_exc_e               exc_o;
    logic [3:0]             delay;
    logic [2:0]             fault;
    int                     n_errors;
    int                     comparisons;
    initial sys_clk_i = 1'b0;
    always #4 sys_clk_i = ~sys_clk_i;
    wsa_store_align wsa_store_align_inst (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
        .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_i(req_i),
        .endian_select_i(endian_select_i), .xlat_req_o(xlat_req_o),
        .virt_addr_o(virt_addr_o), .xlat_valid_i(xlat_valid_i), .xlat_i(xlat_i),
        .store_valid_o(store_valid_o), .store_o(store_o), .done_o(done_o), .exc_o(exc_o));
    wsa_xlat_model wsa_xlat_model_inst (.sys_clk_i(sys_clk_i), .xlat_req_i(xlat_req_o),
        .virt_addr_i(virt_addr_o), .delay_i(delay), .fault_i(fault),
        .xlat_valid_o(xlat_valid_i), .xlat_o(xlat_i));
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t mismatch seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test;
        $display("Errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // One request; expectations worked out from the placement rules
    task automatic run_op(input logic [5:0] opc, input logic [31:0] base_lo,
                          input logic [15:0] off, input logic [31:0] src, input logic be);
        logic [31:0]  va;
        logic [31:0]  pa;
        logic [1:0]   w;
        logic [1:0]   b;
        logic [2:0]   exp_exc;
        logic         exp_st;
        logic         translated;
        logic         seen_st;
        logic [127:0] exp_data;
        logic [15:0]  exp_ben;
        logic [31:0]  exp_addr;
        wsa_store_s   got;
        int           n;
        va = base_lo + {{16{off[15]}}, off};
        pa = va ^ PA_XOR;
        w = va[3:2] ^ {be, be};
        b = va[1:0] ^ {be, be};
        exp_exc = fault[2] ? WSA_EXC_REFILL : fault[1] ? WSA_EXC_INVALID :
                  fault[0] ? WSA_EXC_MODIFIED : WSA_EXC_NONE;
        exp_data = {96'h0, src} << (32 * w);
        exp_ben = 16'h000F << (4 * w);
        exp_addr = pa ^ {28'h0, be, be, 2'b00};
        if (opc == `WSA_OPC_LEFT_STORE) begin
            exp_data = ({96'h0, src} >> (8 * (3 - b))) << (32 * w);
            exp_ben = (16'h000F >> (3 - b)) << (4 * w);
            exp_addr = be ? pa ^ 32'h0000_000F : {pa[31:2], 2'b00};
        end else if (opc != `WSA_OPC_WORD_STORE) begin
            exp_exc = WSA_EXC_NOSTORE;
        end else if (va[1:0] != 2'b00) begin
            exp_exc = WSA_EXC_ADDR;
        end
        exp_st = (exp_exc == WSA_EXC_NONE);
        translated = (opc == `WSA_OPC_LEFT_STORE) ||
                     (opc == `WSA_OPC_WORD_STORE && va[1:0] == 2'b00);
        seen_st = 1'b0;
        got = '0;
        endian_select_i = be;
        req_i = {opc, 5'h01, 5'h02, off, 32'hA5A5_5A5A, base_lo, 32'h5A5A_A5A5, src};
        req_valid_i = 1'b1;
        @(negedge sys_clk_i);
        req_valid_i = 1'b0;
        req_i = ~req_i;
        chk(xlat_req_o, translated);
        for (n = 0; n < 20 && !done_o; n++) begin
            if (xlat_req_o) begin
                chk(virt_addr_o, va);
                chk(req_ready_o, 1'b0);
            end
            @(negedge sys_clk_i);
            if (store_valid_o) begin
                seen_st = 1'b1;
                got = store_o;
            end
        end
        if (n == 20) begin
            n_errors++;
            $display("[FAIL] %0t no completion", $time);
            end_of_test();
        end
        chk(n, translated ? 32'(delay) + 1 : 0);
        chk(exc_o, exp_exc);
        chk(seen_st, exp_st);
        if (exp_st) begin
            chk(got.addr, exp_addr);
            chk(got.data, exp_data);
            chk(got.ben, exp_ben);
        end
        @(negedge sys_clk_i);
        chk({done_o, store_valid_o, req_ready_o}, 3'b001);
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic sc_word_lanes;
        for (int i = 0; i < 8; i++) begin
            delay = i[3:0];
            run_op(`WSA_OPC_WORD_STORE, 32'h100, 16'(4 * (i % 4)), 32'h1122_3344, i[2]);
        end
    endtask
    task automatic sc_sign_extend;
        run_op(`WSA_OPC_WORD_STORE, 32'h0000_1000, 16'hFFF8, 32'hCAFE_0001, 1'b0);
        run_op(`WSA_OPC_WORD_STORE, 32'hFFFF_FFFC, 16'h0008, 32'hCAFE_0002, 1'b1);
    endtask
    task automatic sc_misaligned;
        fault = 3'h4;
        for (int i = 1; i < 4; i++) begin
            run_op(`WSA_OPC_WORD_STORE, 32'h300, 16'(i), 32'h0BAD_F00D, i[0]);
        end
        fault = 3'h0;
    endtask
    task automatic sc_left_all;
        for (int i = 0; i < 32; i++) begin
            delay = i[3:0] & 4'h3;
            run_op(`WSA_OPC_LEFT_STORE, 32'h200, 16'(i % 16), 32'hA1B2_C3D4, i[4]);
        end
    endtask
    // Priority shows only with several faults at once
    task automatic sc_faults;
        for (int i = 1; i < 8; i++) begin
            fault = i[2:0];
            run_op(`WSA_OPC_WORD_STORE, 32'h400, 16'h0004, 32'h5555_AAAA, 1'b0);
            run_op(`WSA_OPC_LEFT_STORE, 32'h400, 16'h0006, 32'h5555_AAAA, 1'b1);
        end
        fault = 3'h0;
    endtask
    task automatic sc_bad_opcode;
        run_op(6'h23, 32'h500, 16'h0000, 32'h1234_5678, 1'b0);
        run_op(6'h2E, 32'h500, 16'h0001, 32'h1234_5678, 1'b1);
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        n_errors = 0;
        comparisons = 0;
        sys_rst_i = 1'b1;
        req_valid_i = 1'b0;
        req_i = '0;
        endian_select_i = 1'b0;
        delay = 4'h0;
        fault = 3'h0;
        repeat (16) @(negedge sys_clk_i);
        sys_rst_i = 1'b0;
        chk({req_ready_o, xlat_req_o, done_o, store_valid_o, exc_o}, 7'h40);
        chk({store_o.addr, store_o.ben, virt_addr_o}, 80'h0);
        sc_word_lanes();
        sc_sign_extend();
        sc_misaligned();
        sc_left_all();
        sc_faults();
        sc_bad_opcode();
        end_of_test();
    end
endmodule
